// ### i2m_host.sv
// Functional notes
// [R1] Controller is sole master, drives the clock
// [R2] Two data bytes, upper byte first
// [R3] Data changes only while clock low
// [R4] Device leaves data line released at power-up
// [R5] Device ignores bus until a START
// [R6] Device ignores START during its power-up
// [R7] Every operation ends with STOP
// [R8] Standard rate is the SMBus rate
// [R9] Address byte: seven id bits, direction last
// [R10] Address built from three two-bit straps
// [R11] Device acknowledges only its own address
// [R12] Current-address read uses device pointer
// [R13] Same slave address in both read phases
// [R14] Write: address, pointer, two bytes, STOP
// [R15] Read: address, pointer, restart, read address
// [R16] Acknowledge first byte, refuse second, STOP
// [R17] Device pointer loads and advances per pair; the model advances it after read pairs only, not on writes
// [R18] High-speed code switches rate until STOP
// [R19] Missing address acknowledge ends the transfer
// [R20] Device commits word after both bytes
`timescale 1ns/1ps
`default_nettype none
`include "i2m_defs.svh"

module i2m_host #(
  parameter logic [2:0] HS_ID = 3'h0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqCurrent,
  input wire logic reqHs,
  input wire logic [1:0] addrStrapHigh,
  input wire logic [1:0] addrStrapMid,
  input wire logic [1:0] addrStrapLow,
  input wire logic [7:0] reqWordAddr,
  input wire logic [15:0] reqData,
  output logic reqReady,
  output logic reqDone,
  output logic ackError,
  output logic hsActive,
  output logic [15:0] rdData,
  input wire logic sdaIn,
  output wire logic sdaOut,
  output wire logic sdaOe,
  output wire logic sclOut,
  output wire logic sclOe
);

  // ----------------------------------------
  // Address helpers
  // ----------------------------------------
  function automatic logic strapReserved(input logic [1:0] hi, input logic [1:0] mid, input logic [1:0] lo);
    logic r;
    r = (hi == `I2M_STRAP_SCL && (mid == `I2M_STRAP_SDA || mid == `I2M_STRAP_SCL))
      || (hi == `I2M_STRAP_SDA && mid == `I2M_STRAP_GND && lo == `I2M_STRAP_SUPPLY);
    return r;
  endfunction : strapReserved

  function automatic logic [7:0] byteFor(input i2m_pkg::i2m_phase_t p, input logic [6:0] a,
                                         input logic [7:0] w, input logic [15:0] d,
                                         input logic [2:0] hsId);
    logic [7:0] b;
    b = 8'hFF;
    case (p)
      i2m_pkg::I2M_PH_HSCODE: b = {`I2M_HS_PREFIX, hsId}; // see [R18]
      i2m_pkg::I2M_PH_ADDRW: b = {a, `I2M_DIR_WRITE}; // see [R9]
      i2m_pkg::I2M_PH_PTR: b = w;
      i2m_pkg::I2M_PH_MSB: b = d[15:8]; // see [R2]
      i2m_pkg::I2M_PH_LSB: b = d[7:0];
      i2m_pkg::I2M_PH_ADDRR: b = {a, `I2M_DIR_READ}; // see [R13]
      default: b = 8'hFF;
    endcase
    return b;
  endfunction : byteFor

  // ----------------------------------------
  // State
  // ----------------------------------------
  i2m_bit_if bitBus ();

  i2m_pkg::i2m_state_t state_reg, state_next;
  i2m_pkg::i2m_phase_t phase_reg, phase_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic write_reg, write_next;
  logic [6:0] slave_reg, slave_next;
  logic [7:0] word_reg, word_next;
  logic [15:0] wrData_reg, wrData_next;
  logic [15:0] rdData_reg, rdData_next;
  logic fast_reg, fast_next;
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  logic err_reg, err_next;
  logic [7:0] rxByte;
  logic curRead_reg, curRead_next;

  assign rxByte = {shift_reg[6:0], bitBus.rxBit};

  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    write_next = write_reg;
    slave_next = slave_reg;
    word_next = word_reg;
    wrData_next = wrData_reg;
    rdData_next = rdData_reg;
    fast_next = fast_reg;
    ready_next = ready_reg;
    done_next = 1'b0;
    err_next = err_reg;
    case (state_reg)
      i2m_pkg::I2M_ST_IDLE:
      begin
        if (reqValid && ready_reg)
        begin
          if (strapReserved(addrStrapHigh, addrStrapMid, addrStrapLow)) // see [R10]
          begin
            err_next = 1'b1;
            done_next = 1'b1;
          end
          else
          begin
            slave_next = {`I2M_ADDR_LEAD, addrStrapHigh, addrStrapMid, addrStrapLow}; // see [R10]
            write_next = reqWrite;
            word_next = reqWordAddr;
            wrData_next = reqData;
            err_next = 1'b0;
            ready_next = 1'b0;
            state_next = i2m_pkg::I2M_ST_START; // see [R1]
            if (reqHs)
            begin
              phase_next = i2m_pkg::I2M_PH_HSCODE;
            end
            else if (reqCurrent && !reqWrite)
            begin
              phase_next = i2m_pkg::I2M_PH_ADDRR; // see [R12]
            end
            else
            begin
              phase_next = i2m_pkg::I2M_PH_ADDRW;
            end
          end
        end
      end
      i2m_pkg::I2M_ST_START:
      begin
        if (bitBus.done)
        begin
          shift_next = byteFor(phase_reg, slave_reg, word_reg, wrData_reg, HS_ID);
          bitCnt_next = 3'h0;
          state_next = i2m_pkg::I2M_ST_TXBIT;
        end
      end
      i2m_pkg::I2M_ST_TXBIT:
      begin
        if (bitBus.done)
        begin
          shift_next = {shift_reg[6:0], 1'b1};
          bitCnt_next = bitCnt_reg + 3'h1;
          if (bitCnt_reg == 3'h7)
          begin
            state_next = i2m_pkg::I2M_ST_TXACK;
          end
        end
      end
      i2m_pkg::I2M_ST_TXACK:
      begin
        if (bitBus.done)
        begin
          if (phase_reg == i2m_pkg::I2M_PH_HSCODE)
          begin
            // Nobody answers the high-speed code; restart at the fast rate
            fast_next = 1'b1; // see [R18]
            phase_next = (curRead_reg) ? i2m_pkg::I2M_PH_ADDRR : i2m_pkg::I2M_PH_ADDRW;
            state_next = i2m_pkg::I2M_ST_START;
          end
          else if (bitBus.rxBit == `I2M_NACK)
          begin
            err_next = 1'b1; // see [R19]
            state_next = i2m_pkg::I2M_ST_STOP;
          end
          else
          begin
            case (phase_reg)
              i2m_pkg::I2M_PH_ADDRW:
              begin
                phase_next = i2m_pkg::I2M_PH_PTR;
                shift_next = word_reg; // see [R17]
                bitCnt_next = 3'h0;
                state_next = i2m_pkg::I2M_ST_TXBIT;
              end
              i2m_pkg::I2M_PH_PTR:
              begin
                if (write_reg)
                begin
                  phase_next = i2m_pkg::I2M_PH_MSB; // see [R14]
                  shift_next = wrData_reg[15:8];
                  bitCnt_next = 3'h0;
                  state_next = i2m_pkg::I2M_ST_TXBIT;
                end
                else
                begin
                  phase_next = i2m_pkg::I2M_PH_ADDRR; // see [R15]
                  state_next = i2m_pkg::I2M_ST_START;
                end
              end
              i2m_pkg::I2M_PH_MSB:
              begin
                phase_next = i2m_pkg::I2M_PH_LSB; // see [R2]
                shift_next = wrData_reg[7:0];
                bitCnt_next = 3'h0;
                state_next = i2m_pkg::I2M_ST_TXBIT;
              end
              i2m_pkg::I2M_PH_ADDRR:
              begin
                phase_next = i2m_pkg::I2M_PH_RDMSB;
                bitCnt_next = 3'h0;
                state_next = i2m_pkg::I2M_ST_RXBIT;
              end
              default:
              begin
                // Word taken only once both bytes are acknowledged
                state_next = i2m_pkg::I2M_ST_STOP; // see [R20]
              end
            endcase
          end
        end
      end
      i2m_pkg::I2M_ST_RXBIT:
      begin
        if (bitBus.done)
        begin
          shift_next = rxByte;
          bitCnt_next = bitCnt_reg + 3'h1;
          if (bitCnt_reg == 3'h7)
          begin
            if (phase_reg == i2m_pkg::I2M_PH_RDMSB)
            begin
              rdData_next = {rxByte, rdData_reg[7:0]}; // see [R2]
            end
            else
            begin
              rdData_next = {rdData_reg[15:8], rxByte};
            end
            state_next = i2m_pkg::I2M_ST_RXACK;
          end
        end
      end
      i2m_pkg::I2M_ST_RXACK:
      begin
        if (bitBus.done)
        begin
          if (phase_reg == i2m_pkg::I2M_PH_RDMSB)
          begin
            phase_next = i2m_pkg::I2M_PH_RDLSB;
            bitCnt_next = 3'h0;
            state_next = i2m_pkg::I2M_ST_RXBIT;
          end
          else
          begin
            state_next = i2m_pkg::I2M_ST_STOP;
          end
        end
      end
      i2m_pkg::I2M_ST_STOP:
      begin
        if (bitBus.done)
        begin
          fast_next = 1'b0; // see [R18]
          ready_next = 1'b1;
          done_next = 1'b1;
          state_next = i2m_pkg::I2M_ST_IDLE; // see [R7]
        end
      end
      default:
      begin
        state_next = i2m_pkg::I2M_ST_IDLE;
      end
    endcase
  end

  // Current-address choice is kept for the restart after the speed code
  always_comb
  begin
    curRead_next = curRead_reg;
    if (state_reg == i2m_pkg::I2M_ST_IDLE && reqValid && ready_reg)
    begin
      curRead_next = reqCurrent && !reqWrite;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= i2m_pkg::I2M_ST_IDLE;
      phase_reg <= i2m_pkg::I2M_PH_ADDRW;
      shift_reg <= 8'hFF;
      bitCnt_reg <= 3'h0;
      write_reg <= 1'b0;
      slave_reg <= 7'h00;
      word_reg <= 8'h00;
      wrData_reg <= 16'h0000;
      rdData_reg <= 16'h0000;
      fast_reg <= 1'b0;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      curRead_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      write_reg <= write_next;
      slave_reg <= slave_next;
      word_reg <= word_next;
      wrData_reg <= wrData_next;
      rdData_reg <= rdData_next;
      fast_reg <= fast_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      err_reg <= err_next;
      curRead_reg <= curRead_next;
    end
  end

  // ----------------------------------------
  // Bit commands
  // ----------------------------------------
  always_comb
  begin
    bitBus.cmdValid = (state_reg != i2m_pkg::I2M_ST_IDLE);
    bitBus.txBit = 1'b1;
    case (state_reg)
      i2m_pkg::I2M_ST_START: bitBus.cmd = i2m_pkg::I2M_CMD_START; // see [R5], [R6]
      i2m_pkg::I2M_ST_STOP: bitBus.cmd = i2m_pkg::I2M_CMD_STOP; // see [R7]
      i2m_pkg::I2M_ST_TXBIT:
      begin
        bitBus.cmd = i2m_pkg::I2M_CMD_WBIT;
        bitBus.txBit = shift_reg[7];
      end
      i2m_pkg::I2M_ST_RXACK:
      begin
        bitBus.cmd = i2m_pkg::I2M_CMD_WBIT;
        bitBus.txBit = (phase_reg == i2m_pkg::I2M_PH_RDLSB) ? `I2M_NACK : `I2M_ACK; // see [R16]
      end
      default: bitBus.cmd = i2m_pkg::I2M_CMD_RBIT; // see [R11]
    endcase
  end

  // Standard rate is the SMBus rate; fast only after the speed code
  assign bitBus.fast = fast_reg; // see [R8]

  i2m_bit_engine #(
    .CNT_W(8)
  ) u_engine (
    .clk(clk),
    .reset_n(reset_n),
    .bus(bitBus),
    .sdaIn(sdaIn),
    .sclOut(sclOut),
    .sclOe(sclOe),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe)
  );

  assign reqReady = ready_reg;
  assign reqDone = done_reg;
  assign ackError = err_reg;
  assign hsActive = fast_reg;
  assign rdData = rdData_reg;

endmodule : i2m_host

`default_nettype wire

// ### i2m_defs.svh
`ifndef I2M_DEFS_SVH
`define I2M_DEFS_SVH

// ----------------------------------------
// Clock and line rates
// ----------------------------------------
`define I2M_CLK_KHZ 50000
`define I2M_STD_SCL_KHZ 100
`define I2M_HS_SCL_KHZ 3400
// Quarter of a line clock period is a least time, so it rounds up
`define I2M_STD_QTR_CYC ((`I2M_CLK_KHZ + 4 * `I2M_STD_SCL_KHZ - 1) / (4 * `I2M_STD_SCL_KHZ))
`define I2M_HS_QTR_CYC ((`I2M_CLK_KHZ + 4 * `I2M_HS_SCL_KHZ - 1) / (4 * `I2M_HS_SCL_KHZ))

// ----------------------------------------
// Byte layouts
// ----------------------------------------
`define I2M_ADDR_LEAD 1'b1
`define I2M_HS_PREFIX 5'h01
`define I2M_DIR_READ 1'b1
`define I2M_DIR_WRITE 1'b0
`define I2M_ACK 1'b0
`define I2M_NACK 1'b1

// ----------------------------------------
// Strap codes
// ----------------------------------------
`define I2M_STRAP_GND 2'h0
`define I2M_STRAP_SUPPLY 2'h1
`define I2M_STRAP_SDA 2'h2
`define I2M_STRAP_SCL 2'h3

`endif

// ### i2m_pkg.sv
`default_nettype none
package i2m_pkg;

  // ----------------------------------------
  // Bit level commands
  // ----------------------------------------
  typedef enum logic [1:0] {
    I2M_CMD_START = 2'h0,
    I2M_CMD_STOP = 2'h1,
    I2M_CMD_WBIT = 2'h2,
    I2M_CMD_RBIT = 2'h3
  } i2m_cmd_t;

  // ----------------------------------------
  // Transaction states, one bit apart in listed order from IDLE to STOP
  // ----------------------------------------
  typedef enum logic [2:0] {
    I2M_ST_IDLE = 3'h0,
    I2M_ST_START = 3'h1,
    I2M_ST_TXBIT = 3'h3,
    I2M_ST_TXACK = 3'h2,
    I2M_ST_RXBIT = 3'h6,
    I2M_ST_RXACK = 3'h7,
    I2M_ST_STOP = 3'h5
  } i2m_state_t;

  // ----------------------------------------
  // Byte being moved
  // ----------------------------------------
  typedef enum logic [2:0] {
    I2M_PH_HSCODE = 3'h0,
    I2M_PH_ADDRW = 3'h1,
    I2M_PH_PTR = 3'h2,
    I2M_PH_MSB = 3'h3,
    I2M_PH_LSB = 3'h4,
    I2M_PH_ADDRR = 3'h5,
    I2M_PH_RDMSB = 3'h6,
    I2M_PH_RDLSB = 3'h7
  } i2m_phase_t;

endpackage : i2m_pkg

`default_nettype wire

// ### i2m_bit_if.sv
`timescale 1ns/1ps
`default_nettype none

interface i2m_bit_if;
  i2m_pkg::i2m_cmd_t cmd;
  logic cmdValid;
  logic txBit;
  logic fast;
  logic done;
  logic rxBit;

  modport ctrl (
    output cmd,
    output cmdValid,
    output txBit,
    output fast,
    input done,
    input rxBit
  );

  modport engine (
    input cmd,
    input cmdValid,
    input txBit,
    input fast,
    output done,
    output rxBit
  );
endinterface : i2m_bit_if

`default_nettype wire

// ### i2m_bit_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2m_defs.svh"

module i2m_bit_engine #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  i2m_bit_if.engine bus,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe
);

  localparam logic [CNT_W-1:0] STD_MAX = CNT_W'(`I2M_STD_QTR_CYC - 1);
  localparam logic [CNT_W-1:0] HS_MAX = CNT_W'(`I2M_HS_QTR_CYC - 1);

  // ----------------------------------------
  // Line levels per quarter, {scl, sda}; sda 1 means released
  // ----------------------------------------
  function automatic logic [1:0] lineLevels(input i2m_pkg::i2m_cmd_t c, input logic b, input logic [1:0] q);
    logic [1:0] lv;
    lv = 2'h3;
    case (c)
      i2m_pkg::I2M_CMD_START: lv = (q == 2'h0) ? 2'h1 : (q == 2'h1) ? 2'h3 : (q == 2'h2) ? 2'h2 : 2'h0;
      i2m_pkg::I2M_CMD_STOP: lv = (q == 2'h0) ? 2'h0 : (q == 2'h1) ? 2'h2 : 2'h3;
      i2m_pkg::I2M_CMD_WBIT: lv = {(q == 2'h1) || (q == 2'h2), b};
      i2m_pkg::I2M_CMD_RBIT: lv = {(q == 2'h1) || (q == 2'h2), 1'b1};
      default: lv = 2'h3;
    endcase
    return lv;
  endfunction : lineLevels

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic sdaMeta_reg;
  logic sdaSync_reg;
  logic busy_reg, busy_next;
  i2m_pkg::i2m_cmd_t cmd_reg, cmd_next;
  logic bit_reg, bit_next;
  logic [1:0] qtr_reg, qtr_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic scl_reg, scl_next;
  logic sdaOe_reg, sdaOe_next;
  logic rx_reg, rx_next;
  logic done_reg, done_next;
  logic [CNT_W-1:0] qtrMax;
  logic [1:0] lv;

  // Rate switches only between commands, so a bit never mixes two rates
  assign qtrMax = bus.fast ? HS_MAX : STD_MAX;

  always_comb
  begin
    busy_next = busy_reg;
    cmd_next = cmd_reg;
    bit_next = bit_reg;
    qtr_next = qtr_reg;
    cnt_next = cnt_reg;
    scl_next = scl_reg;
    sdaOe_next = sdaOe_reg;
    rx_next = rx_reg;
    done_next = 1'b0;
    lv = 2'h3;
    // Not in the done cycle: the controller still shows the finished command
    if (!busy_reg && !done_reg)
    begin
      if (bus.cmdValid)
      begin
        busy_next = 1'b1;
        cmd_next = bus.cmd;
        bit_next = bus.txBit;
        qtr_next = 2'h0;
        cnt_next = '0;
        lv = lineLevels(bus.cmd, bus.txBit, 2'h0);
        scl_next = lv[1]; // see [R1]
        sdaOe_next = ~lv[0]; // see [R3]
      end
    end
    else if (cnt_reg == qtrMax)
    begin
      cnt_next = '0;
      if (qtr_reg == 2'h2 && cmd_reg == i2m_pkg::I2M_CMD_RBIT)
      begin
        rx_next = sdaSync_reg;
      end
      if (qtr_reg == 2'h3)
      begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
      else
      begin
        qtr_next = qtr_reg + 2'h1;
        lv = lineLevels(cmd_reg, bit_reg, qtr_reg + 2'h1);
        scl_next = lv[1];
        sdaOe_next = ~lv[0]; // see [R3]
      end
    end
    else
    begin
      cnt_next = cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sdaMeta_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      busy_reg <= 1'b0;
      cmd_reg <= i2m_pkg::I2M_CMD_STOP;
      bit_reg <= 1'b1;
      qtr_reg <= 2'h0;
      cnt_reg <= '0;
      scl_reg <= 1'b1;
      sdaOe_reg <= 1'b0; // see [R4]
      rx_reg <= 1'b1;
      done_reg <= 1'b0;
    end
    else
    begin
      sdaMeta_reg <= sdaIn;
      sdaSync_reg <= sdaMeta_reg;
      busy_reg <= busy_next;
      cmd_reg <= cmd_next;
      bit_reg <= bit_next;
      qtr_reg <= qtr_next;
      cnt_reg <= cnt_next;
      scl_reg <= scl_next;
      sdaOe_reg <= sdaOe_next;
      rx_reg <= rx_next;
      done_reg <= done_next;
    end
  end

  assign bus.done = done_reg;
  assign bus.rxBit = rx_reg;
  assign sclOut = scl_reg;
  assign sclOe = busy_reg | ~busy_reg;
  // Open drain: data is only ever pulled low
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_reg;

endmodule : i2m_bit_engine

`default_nettype wire

// ### i2m_host_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host port checks
// ----------------------------------------
module i2m_host_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic reqDone,
  input wire logic ackError,
  input wire logic hsActive,
  input wire logic [1:0] addrStrapHigh,
  input wire logic [1:0] addrStrapMid,
  input wire logic [1:0] addrStrapLow,
  input wire logic [15:0] rdData,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic sclOut,
  input wire logic sclOe
);
  logic rsvd;
  logic take;
  assign rsvd = (addrStrapHigh == 2'h3 && addrStrapMid[1]) ||
                (addrStrapHigh == 2'h2 && addrStrapMid == 2'h0 && addrStrapLow == 2'h1);
  assign take = reqValid && reqReady;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  AST_PUSH_PULL_SCL: assert property (sclOe && !sdaOut)
    else $error("clock not driven or data driven high");
  AST_IDLE_LINES: assert property (reqReady && $past(reqReady) |-> sclOut && !sdaOe && !hsActive)
    else $error("bus not idle while ready");
  AST_START_SHAPE: assert property (sclOut && $past(sclOut) && $rose(sdaOe) |-> ##[1:260] !sclOut)
    else $error("start not followed by clock low");
  AST_STOP_SHAPE: assert property (sclOut && $past(sclOut) && $fell(sdaOe) |-> ##[1:260] reqDone)
    else $error("data rose under high clock without ending");
  AST_DONE_READY: assert property (reqDone |-> reqReady ##1 !reqDone)
    else $error("done not a single ready cycle");
  AST_TAKE_BUSY: assert property (take && !rsvd |=> !reqReady && !ackError)
    else $error("accepted request did not start cleanly");
  AST_TAKE_CLOCKS: assert property (take && !rsvd |-> ##[1:20] $fell(sclOut))
    else $error("no clock after accepted request");
  AST_RSVD_DONE: assert property (take && rsvd |-> ##[1:2] (reqDone && ackError))
    else $error("reserved straps not refused");
  AST_RSVD_QUIET: assert property (take && rsvd |=> (sclOut && !sdaOe) [*2])
    else $error("bus moved for reserved straps");
  AST_RDDATA_HOLD: assert property ($changed(rdData) |-> !reqReady || reqDone)
    else $error("read word changed while idle");
endmodule : i2m_host_props

bind i2m_host i2m_host_props uChk (.clk, .reset_n, .reqValid, .reqReady, .reqDone, .ackError, .hsActive,
  .addrStrapHigh, .addrStrapMid, .addrStrapLow, .rdData, .sdaOut, .sdaOe, .sclOut, .sclOe);

`default_nettype wire

// ### i2m_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Register slave on the wires
// ----------------------------------------
module i2m_dev_model #(
  parameter logic [6:0] DEV_ADDR = 7'h49,
  parameter int BOOT_CYC = 3
) (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic sdaLow
);
  logic [15:0] regs [256];
  logic [7:0] ptr, sh, upper, txByte;
  logic sclQ, sdaQ, active, reading, masterAck, hsMode;
  int bitCnt, byteIdx, rdIdx, bootCnt;
  initial begin
    foreach (regs[i]) regs[i] = {8'hA5, 8'(i)};
    ptr = 8'h00;
    sdaLow = 1'b0;
    {sclQ, sdaQ, active, reading, hsMode} = 5'h18;
    bootCnt = 0;
  end
  // Lines are sampled on clk, so a clock fall and data change in one step never reads as START
  always @(posedge clk) begin
    if (bootCnt < BOOT_CYC) bootCnt++;
    if (sclQ && scl && sdaQ && !sda) begin
      if (bootCnt == BOOT_CYC) begin
        {active, reading, sdaLow} = 3'h4;
        // The START's own clock fall is not a data bit
        {bitCnt, byteIdx, rdIdx} = {32'hFFFFFFFF, 32'd0, 32'd0};
      end
    end else if (sclQ && scl && !sdaQ && sda) begin
      {active, hsMode, sdaLow} = 3'h0;
    end else if (active && !sclQ && scl) begin
      if (bitCnt < 8) sh = {sh[6:0], sda};
      else masterAck = !sda;
    end else if (active && sclQ && !scl) begin
      bitCnt++;
      if (bitCnt == 8 && reading) sdaLow = 1'b0;
      else if (bitCnt == 8) begin
        sdaLow = 1'b1;
        if (byteIdx == 0 && sh[7:3] == 5'h01) {hsMode, active, sdaLow} = 3'h4;
        else if ((byteIdx == 0 && sh[7:1] != DEV_ADDR) || byteIdx > 3) {active, sdaLow} = 2'h0;
        else if (byteIdx == 0) reading = sh[0];
        else if (byteIdx == 1) ptr = sh;
        else if (byteIdx == 2) upper = sh;
        byteIdx++;
      end else if (bitCnt == 9) begin
        bitCnt = 0;
        sdaLow = 1'b0;
        if (!reading && byteIdx == 4) regs[ptr] = {upper, sh};
        if (reading && (rdIdx == 0 || (masterAck && rdIdx == 1))) begin
          txByte = (rdIdx == 0) ? regs[ptr][15:8] : regs[ptr][7:0];
          if (rdIdx == 1) ptr++;
          rdIdx++;
          sdaLow = !txByte[7];
        end else if (reading) active = 1'b0;
      end else if (reading) sdaLow = !txByte[7 - bitCnt];
    end
    sclQ = scl;
    sdaQ = sda;
  end
endmodule : i2m_dev_model

`default_nettype wire

// ### i2m_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2m_defs.svh"
module i2m_host_tb_top;
  localparam int LIMIT = 30000;
  typedef struct {logic wr; logic cur; logic hs; logic [7:0] ptr; logic [15:0] data; logic [15:0] expRd;} i2m_row_t;
  logic clk, reset_n, reqValid, reqWrite, reqCurrent, reqHs, reqReady, reqDone, ackError, hsActive;
  logic [1:0] addrStrapHigh, addrStrapMid, addrStrapLow;
  logic [7:0] reqWordAddr;
  logic [15:0] reqData, rdData, bitPer;
  logic sdaOut, sdaOe, sclOut, sclOe, devLow, sclQ;
  wire logic scl, sda, sdaIn;
  int numErrors, checked, perCnt, riseCnt;
  i2m_row_t rows [6] = '{
    '{1'b0, 1'b1, 1'b1, 8'h00, 16'h0000, 16'hA500},
    '{1'b1, 1'b0, 1'b0, 8'h10, 16'h1234, 16'h0000},
    '{1'b0, 1'b0, 1'b1, 8'h10, 16'h0000, 16'h1234},
    '{1'b0, 1'b1, 1'b1, 8'h00, 16'h0000, 16'hA511},
    '{1'b1, 1'b0, 1'b1, 8'hFF, 16'hBEEF, 16'h0000},
    '{1'b0, 1'b0, 1'b1, 8'hFF, 16'h0000, 16'hBEEF}};
  // Pull-up; the delay keeps model writes off the host's sampling edge
  assign scl = sclOe ? sclOut : 1'b1;
  assign #1 sda = (sdaOe ? sdaOut : 1'b1) & !devLow;
  assign sdaIn = sda;
  i2m_host uut (.clk, .reset_n, .reqValid, .reqWrite, .reqCurrent, .reqHs, .addrStrapHigh, .addrStrapMid,
    .addrStrapLow, .reqWordAddr, .reqData, .reqReady, .reqDone, .ackError, .hsActive, .rdData, .sdaIn,
    .sdaOut, .sdaOe, .sclOut, .sclOe);
  i2m_dev_model #(.DEV_ADDR(7'h49)) uDev (.clk, .scl, .sda, .sdaLow(devLow));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // Clock period of the second bit
  // ----------------------------------------
  always @(posedge clk) begin
    sclQ <= scl;
    perCnt <= (scl && !sclQ) ? 0 : perCnt + 1;
    riseCnt <= reqReady ? 0 : riseCnt + int'(scl && !sclQ);
    if (scl && !sclQ && riseCnt == 2) bitPer <= 16'(perCnt + 1);
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finalReport;
    $display("checked=%0d numErrors=%0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finalReport
  task automatic checkBit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: %s is %b", $time, what, got);
    end
  endtask : checkBit
  task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: word %h not %h", $time, got, exp);
    end
  endtask : checkWord
  task automatic doReq(input logic wr, input logic cur, input logic hs, input logic [7:0] p, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {reqWrite, reqCurrent, reqHs, reqWordAddr, reqData} <= {wr, cur, hs, p, d};
    reqValid <= 1'b1;
    @(posedge clk);
    reqValid <= 1'b0;
    #1;
    while (reqDone !== 1'b1 && n < LIMIT) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= LIMIT) begin
      numErrors++;
      $display("unexpected at %0t: request never finished", $time);
      finalReport();
    end
  endtask : doReq
  initial begin
    {reset_n, reqValid, reqWrite, reqCurrent, reqHs, reqWordAddr, reqData} = '0;
    {addrStrapHigh, addrStrapMid, addrStrapLow} = 6'h09;
    {numErrors, checked} = {32'd0, 32'd0};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      doReq(rows[i].wr, rows[i].cur, rows[i].hs, rows[i].ptr, rows[i].data);
      checkBit(ackError, 1'b0, "ack error");
      if (!rows[i].wr) checkWord(rdData, rows[i].expRd);
      // Four quarters plus two handover cycles between bit commands
      if (i == 1) checkWord(bitPer, 16'(4 * `I2M_STD_QTR_CYC + 2));
    end
    // Address mismatch: no acknowledge, transfer closed
    addrStrapLow <= 2'h3;
    doReq(1'b0, 1'b1, 1'b0, 8'h00, 16'h0000);
    checkBit(ackError, 1'b1, "missing nack");
    // Reserved strap combinations, refused without bus traffic
    foreach (rows[i]) begin
      if (i < 3) begin
        {addrStrapHigh, addrStrapMid, addrStrapLow} <= (i == 0) ? 6'h38 : (i == 1) ? 6'h3D : 6'h21;
        doReq(1'b0, 1'b1, 1'b1, 8'h00, 16'h0000);
        checkBit(ackError, 1'b1, "reserved straps");
      end
    end
    // Pointer wrapped from FF to 00 after the last pair
    {addrStrapHigh, addrStrapMid, addrStrapLow} <= 6'h09;
    doReq(1'b0, 1'b1, 1'b1, 8'h00, 16'h0000);
    checkBit(ackError, 1'b0, "error not cleared");
    checkWord(rdData, 16'hA500);
    // Reset in mid transfer
    @(posedge clk);
    {reqWrite, reqCurrent, reqHs, reqValid} <= 4'h7;
    @(posedge clk);
    reqValid <= 1'b0;
    repeat (300) @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    #1;
    checkBit(sdaOe, 1'b0, "data driven in reset");
    checkBit(sclOut & reqReady & !reqDone & !hsActive & !ackError, 1'b1, "reset state");
    checkWord(rdData, 16'h0000);
    // Cut transfer moved no data, so the pointer still stands at 01
    reset_n <= 1'b1;
    doReq(1'b0, 1'b1, 1'b1, 8'h00, 16'h0000);
    checkBit(ackError, 1'b0, "ack after reset");
    checkWord(rdData, 16'hA501);
    finalReport();
  end
endmodule : i2m_host_tb_top

`default_nettype wire
